// File: core/cag_addr_gen.v
// Behaviour
// - pc advances by instruction byte length
// - relative branch adds displacement to next
// - displacement sign extended from bit seven
// - short branch and conditionals use relative
// - absolute call/branch loads sixteen-bit immediate
// - short fixed call lands in 0800-0FFF
// - table call reads vector 40-7F
// - register branch copies accumulator pair
// - multiply uses accumulator, product to pair
// - divide reads and writes accumulator pair
// - adjust and nibble rotates use accumulator
// - register chosen by code within bank
// - direct mode uses sixteen-bit immediate
// - short direct maps to FE20-FF1F
// - short direct bit eight from immediate
// - sfr mode prefixes all-ones upper byte
// - indirect uses selected pointer pair contents
// - memory size select resets to CFh
`include "cag_defs.vh"

module cag_addr_gen #(
    parameter AW = 16
) (
    input  wire          ref_clk,
    input  wire          rst_b,
    input  wire          step,
    input  wire [2:0]    instr_length,
    input  wire [5:0]    branch_kind,
    input  wire          branch_taken,
    input  wire [7:0]    signed_branch_displacement,
    input  wire [15:0]   imm16,
    input  wire [10:0]   imm11,
    input  wire [4:0]    table_vector_call,
    input  wire [15:0]   table_data,
    input  wire [6:0]    operand_mode,
    input  wire [7:0]    imm8,
    input  wire          pair_mode,
    input  wire [2:0]    byte_register_code,
    input  wire [1:0]    pair_register_code,
    input  wire [2:0]    implied_op,
    input  wire          bank_select_low,
    input  wire          bank_select_high,
    input  wire [15:0]   accumulator_pair,
    input  wire [15:0]   pointer_pair_data,
    input  wire          memory_size_write,
    input  wire [7:0]    memory_size_data,
    output reg  [AW-1:0] pc,
    output wire [15:0]   table_addr,
    output reg  [15:0]   operand_addr,
    output reg           operand_is_reg,
    output reg  [4:0]    reg_index,
    output wire [4:0]    pointer_index,
    output reg           acc_pair_write,
    output reg  [7:0]    memory_size_select
);
    reg  [1:0]  rst_sync;
    wire        rst_n_i;
    wire [15:0] next_seq;
    wire [15:0] rel_target;
    wire [4:0]  byte_index;
    wire [4:0]  pair_low_index;
    reg  [15:0] next_pc;
    reg  [15:0] next_oaddr;
    reg         next_is_reg;
    reg  [4:0]  next_ridx;
    reg         next_accw;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_i = rst_sync[1];

    cag_pc_adder u_adder (
        .pc                         (pc),
        .instr_length               (instr_length),
        .signed_branch_displacement (signed_branch_displacement),
        .next_seq                   (next_seq),
        .rel_target                 (rel_target)
    );

    cag_reg_select u_sel (
        .bank_select_low    (bank_select_low),
        .bank_select_high   (bank_select_high),
        .byte_register_code (byte_register_code),
        .pair_register_code (pair_register_code),
        .byte_index         (byte_index),
        .pair_low_index     (pair_low_index)
    );

    // vector slot address, two bytes per entry
    assign table_addr    = `CAG_TBL_BASE | {10'h000, table_vector_call, 1'b0};
    assign pointer_index = pair_low_index;

    always @* begin
        next_pc = next_seq;
        if (branch_taken) begin
            case (branch_kind)
                `CAG_BR_REL: next_pc = rel_target;
                `CAG_BR_ABS: next_pc = imm16;
                `CAG_BR_FIX: next_pc = `CAG_FIX_BASE | {5'h00, imm11};
                `CAG_BR_TBL: next_pc = table_data;
                `CAG_BR_REG: next_pc = accumulator_pair;
                default:     next_pc = next_seq;
            endcase
        end
    end

    always @* begin
        next_oaddr  = 16'h0000;
        next_is_reg = 1'b0;
        next_ridx   = 5'h00;
        next_accw   = 1'b0;
        case (operand_mode)
            `CAG_OP_IMPL: begin
                next_is_reg = 1'b1;
                case (implied_op)
                    `CAG_IMP_MUL: begin
                        next_ridx = {bank_select_high, bank_select_low, `CAG_ACC_CODE};
                        next_accw = 1'b1;
                    end
                    `CAG_IMP_DIV: begin
                        next_ridx = {bank_select_high, bank_select_low, `CAG_ACC_PAIR, 1'b0};
                        next_accw = 1'b1;
                    end
                    `CAG_IMP_ADJA, `CAG_IMP_ADJS, `CAG_IMP_RORN, `CAG_IMP_ROLN: begin
                        next_ridx = {bank_select_high, bank_select_low, `CAG_ACC_CODE};
                    end
                    default: next_is_reg = 1'b0;
                endcase
            end
            `CAG_OP_REG: begin
                next_is_reg = 1'b1;
                next_ridx   = pair_mode ? pair_low_index : byte_index;
            end
            `CAG_OP_DIR:   next_oaddr = imm16;
            `CAG_OP_SHORT: begin
                // bit eight set only below 20h
                next_oaddr = {`CAG_SHORT_HIGH, (imm8 < `CAG_SHORT_LIMIT), imm8};
            end
            `CAG_OP_SFR:   next_oaddr = {`CAG_SFR_HIGH, imm8};
            `CAG_OP_IND:   next_oaddr = pointer_pair_data;
            default:       next_oaddr = 16'h0000;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc                 <= `CAG_PC_RST;
            operand_addr       <= 16'h0000;
            operand_is_reg     <= 1'b0;
            reg_index          <= 5'h00;
            acc_pair_write     <= 1'b0;
            memory_size_select <= `CAG_MEMSIZE_RST;
        end else begin
            if (step) begin
                pc <= next_pc;
            end
            operand_addr   <= next_oaddr;
            operand_is_reg <= next_is_reg;
            reg_index      <= next_ridx;
            acc_pair_write <= next_accw;
            if (memory_size_write) begin
                memory_size_select <= memory_size_data;
            end
        end
    end
endmodule

// File: core/cag_defs.vh
`ifndef CAG_DEFS_VH
`define CAG_DEFS_VH

// branch source selection, one-hot
`define CAG_BR_SEQ        6'h01
`define CAG_BR_REL        6'h02
`define CAG_BR_ABS        6'h04
`define CAG_BR_FIX        6'h08
`define CAG_BR_TBL        6'h10
`define CAG_BR_REG        6'h20

// operand address mode, one-hot
`define CAG_OP_IMPL       7'h01
`define CAG_OP_REG        7'h02
`define CAG_OP_DIR        7'h04
`define CAG_OP_SHORT      7'h08
`define CAG_OP_SFR        7'h10
`define CAG_OP_IND        7'h20
`define CAG_OP_NONE       7'h40

// address constants
`define CAG_FIX_BASE      16'h0800
`define CAG_TBL_BASE      16'h0040
`define CAG_SHORT_HIGH    7'h7F
`define CAG_SHORT_LIMIT   8'h20
`define CAG_SFR_HIGH      8'hFF
`define CAG_MEMSIZE_RST   8'hCF
`define CAG_PC_RST        16'h0000

// implied-operation codes
`define CAG_IMP_NONE      3'h0
`define CAG_IMP_MUL       3'h1
`define CAG_IMP_DIV       3'h2
`define CAG_IMP_ADJA      3'h3
`define CAG_IMP_ADJS      3'h4
`define CAG_IMP_RORN      3'h5
`define CAG_IMP_ROLN      3'h6

// register file coordinates
`define CAG_ACC_CODE      3'h1
`define CAG_ACC_PAIR      2'h0

`endif

// File: core/cag_pc_adder.v
`include "cag_defs.vh"

// next-instruction address and relative target
module cag_pc_adder (
    input  wire [15:0] pc,
    input  wire [2:0]  instr_length,
    input  wire [7:0]  signed_branch_displacement,
    output wire [15:0] next_seq,
    output wire [15:0] rel_target
);
    wire [15:0] disp_ext;

    assign next_seq   = pc + {13'h0000, instr_length};
    assign disp_ext   = {{8{signed_branch_displacement[7]}}, signed_branch_displacement};
    assign rel_target = next_seq + disp_ext;
endmodule

// File: core/cag_reg_select.v
`include "cag_defs.vh"

// turns bank flags and a register code into a flat register index
module cag_reg_select (
    input  wire       bank_select_low,
    input  wire       bank_select_high,
    input  wire [2:0] byte_register_code,
    input  wire [1:0] pair_register_code,
    output wire [4:0] byte_index,
    output wire [4:0] pair_low_index
);
    wire [1:0] bank;

    assign bank = {bank_select_high, bank_select_low};
    assign byte_index     = {bank, byte_register_code};
    assign pair_low_index = {bank, pair_register_code, 1'b0};
endmodule

// File: verif/cag_addr_gen_props.sv
module cag_addr_gen_props (
    input wire        ref_clk, rst_b, step, branch_taken, memory_size_write, acc_pair_write,
    input wire [2:0]  instr_length, implied_op,
    input wire [4:0]  table_vector_call, reg_index,
    input wire [5:0]  branch_kind,
    input wire [6:0]  operand_mode,
    input wire [7:0]  signed_branch_displacement, imm8, memory_size_data, memory_size_select,
    input wire [10:0] imm11,
    input wire [15:0] imm16, table_data, accumulator_pair, pointer_pair_data, pc,
    input wire [15:0] operand_addr, table_addr
);
    wire        br   = step && branch_taken;
    wire [15:0] sext = {{8{signed_branch_displacement[7]}}, signed_branch_displacement};
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // sums are compared at 16 bits, so carries out of the top are dropped
    property p_seq; step && (!branch_taken || branch_kind == 6'h01)
        |=> pc == $past(pc) + $past(instr_length); endproperty
    a_seq: assert property (p_seq) else $error("sequential pc wrong");
    property p_rel; br && branch_kind == 6'h02
        |=> pc == $past(pc) + $past(instr_length) + $past(sext); endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_abs; br && branch_kind == 6'h04 |-> ##1 pc == $past(imm16); endproperty
    a_abs: assert property (p_abs) else $error("absolute target wrong");
    property p_fix; br && branch_kind == 6'h08 |=> pc == {5'h01, $past(imm11)}; endproperty
    a_fix: assert property (p_fix) else $error("fixed call target wrong");
    property p_tbl; br && branch_kind == 6'h10 |=> pc == $past(table_data)
        && table_addr == {9'h000, 1'h1, table_vector_call, 1'h0}; endproperty
    a_tbl: assert property (p_tbl) else $error("table call wrong");
    property p_rbr; br && branch_kind == 6'h20 |=> pc == $past(accumulator_pair); endproperty
    a_rbr: assert property (p_rbr) else $error("register branch wrong");
    property p_short; operand_mode == 7'h08
        |=> operand_addr == {7'h7F, $past(imm8) < 8'h20, $past(imm8)}; endproperty
    a_short: assert property (p_short) else $error("short direct address wrong");
    property p_sfr; operand_mode == 7'h10 |=> operand_addr == {8'hFF, $past(imm8)}; endproperty
    a_sfr: assert property (p_sfr) else $error("sfr address wrong");
    property p_dir; operand_mode == 7'h04 |=> operand_addr == $past(imm16); endproperty
    a_dir: assert property (p_dir) else $error("direct address wrong");
    property p_ind; operand_mode == 7'h20 |=> operand_addr == $past(pointer_pair_data); endproperty
    a_ind: assert property (p_ind) else $error("indirect address wrong");
    property p_mul; operand_mode == 7'h01 && implied_op == 3'h1
        |=> acc_pair_write && reg_index[2:0] == 3'h1; endproperty
    a_mul: assert property (p_mul) else $error("multiply operands wrong");
    property p_ms; memory_size_write |=> memory_size_select == $past(memory_size_data); endproperty
    a_ms: assert property (p_ms) else $error("memory size write lost");
    c_rel: cover property (br && branch_kind == 6'h02);
    c_short: cover property (operand_mode == 7'h08 && imm8 < 8'h20);
    c_tbl: cover property (br && branch_kind == 6'h10);
endmodule

bind cag_addr_gen cag_addr_gen_props cag_addr_gen_props_inst (.*);

// File: verif/cag_addr_gen_tb.sv
module cag_addr_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = '0, rst_b = '0, step = '0, branch_taken = '0, pair_mode = '0;
    logic        bank_select_low = '0, bank_select_high = '0, memory_size_write = '0;
    logic        operand_is_reg, acc_pair_write;
    logic [2:0]  instr_length = 3'h1, byte_register_code = '0, implied_op = '0;
    logic [1:0]  pair_register_code = '0;
    logic [4:0]  table_vector_call = '0, reg_index, pointer_index;
    logic [5:0]  branch_kind = 6'h01;
    logic [6:0]  operand_mode = 7'h40;
    logic [7:0]  signed_branch_displacement = '0, imm8 = '0, memory_size_data = '0;
    logic [7:0]  memory_size_select;
    logic [10:0] imm11 = '0;
    logic [15:0] imm16 = '0, table_data = '0, accumulator_pair = '0, pointer_pair_data = '0;
    logic [15:0] pc, table_addr, operand_addr;
    int          failures = 0, n_tests = 0, cyc = 0;
    cag_addr_gen cag_addr_gen_inst (.*);
    always #2 ref_clk = ~ref_clk;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    // step drops for a cycle between branches so it is never driven twice at one time
    task br(input logic [5:0] k, input logic t, input logic [2:0] n, input logic [15:0] e);
        branch_kind = k;
        branch_taken = t;
        instr_length = n;
        step = 1'h1;
        tick;
        step = '0;
        chk(pc, e);
        tick;
    endtask
    task t_ms;
        chk(16'(memory_size_select), 16'h00CF);
        memory_size_data = 8'h42;
        memory_size_write = 1'h1;
        tick;
        memory_size_write = '0;
        chk(16'(memory_size_select), 16'h0042);
    endtask
    task t_pc;
        imm16 = 16'hFFFE;
        br(6'h04, 1'h1, 3'h3, 16'hFFFE);
        br(6'h01, 1'h1, 3'h3, 16'h0001);
        br(6'h04, 1'h0, 3'h2, 16'h0003);
    endtask
    task t_rel;
        signed_branch_displacement = 8'h80;
        br(6'h02, 1'h1, 3'h2, 16'hFF85);
        signed_branch_displacement = 8'h7F;
        br(6'h02, 1'h1, 3'h2, 16'h0006);
        signed_branch_displacement = 8'hFE;
        br(6'h02, 1'h0, 3'h2, 16'h0008);
    endtask
    task t_far;
        imm11 = 11'h7FF;
        table_vector_call = 5'h1F;
        table_data = 16'hABCD;
        accumulator_pair = 16'h5A3C;
        br(6'h08, 1'h1, 3'h3, 16'h0FFF);
        chk(table_addr, 16'h007E);
        br(6'h10, 1'h1, 3'h1, 16'hABCD);
        br(6'h20, 1'h1, 3'h1, 16'h5A3C);
        imm11 = 11'h000;
        br(6'h08, 1'h1, 3'h3, 16'h0800);
    endtask
    task t_opnd;
        logic [7:0]  sv[4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
        logic [15:0] se[4] = '{16'hFF00, 16'hFF1F, 16'hFE20, 16'hFEFF};
        operand_mode = 7'h08;
        foreach (sv[i]) begin
            imm8 = sv[i];
            tick;
            chk(operand_addr, se[i]);
        end
        operand_mode = 7'h10;
        imm8 = 8'hE0;
        tick;
        chk(operand_addr, 16'hFFE0);
        operand_mode = 7'h04;
        imm16 = 16'hFE00;
        tick;
        chk(operand_addr, 16'hFE00);
        operand_mode = 7'h20;
        pointer_pair_data = 16'hC0DE;
        bank_select_high = 1'h1;
        pair_register_code = 2'h3;
        tick;
        chk(operand_addr, 16'hC0DE);
        chk(16'(pointer_index), 16'h0016);
        operand_mode = 7'h02;
        byte_register_code = 3'h5;
        tick;
        chk(16'({operand_is_reg, reg_index}), 16'h0035);
        pair_mode = 1'h1;
        tick;
        chk(16'({operand_is_reg, reg_index}), 16'h0036);
        pair_mode = '0;
    endtask
    task t_impl;
        bank_select_high = '0;
        operand_mode = 7'h01;
        for (int i = 1; i < 7; i++) begin
            implied_op = 3'(i);
            tick;
            chk(16'({acc_pair_write, reg_index}),
                16'({i < 3, i == 2 ? 5'h00 : 5'h01}));
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        rst_b = 1'h1;
        repeat (3) tick;
        t_ms;
        t_pc;
        t_rel;
        t_far;
        t_opnd;
        t_impl;
        tally_and_finish;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 500) begin
            failures++;
            tally_and_finish;
        end
    end
endmodule
